// ==== rtl/fpec_top.sv ====
// Flash program/erase sequencer: control registers, holding latches, operation FSM
// Function
// - Processor is stalled while a program or erase operation runs
// - Setting bit 15 launches the operation; hardware clears it on completion
// - Start bit can only be set by software; reads one while active
// - Bit 14 write enable must be one or operations are inhibited
// - Bit 13 error flag sets on improper attempt or termination
// - Bit 6 selects erase (one) or program (zero) for the next start
// - Code 1111 with erase bulk-erases the whole array, else nothing
// - Code 0011 without erase programs one word, else nothing
// - Code 0010 with erase erases one page, else nothing
// - Code 0001 without erase programs one row from the latches, else nothing
// - Bulk erase only allowed in external serial programming mode
// - Undefined operation codes never start a flash operation
// - Control bits reset only on power-on reset
// - Bits 12 to 7 and 5 to 4 read as zero
// - Erasing the last page clears configuration words, enabling code protection
// - Table writes go to holding latches, moved to the array on programming
// - Rows are 64 words; page erase clears eight aligned rows
`timescale 1ns/1ns
module fpec_top
    import fpec_pkg::*;
#(
    parameter logic [TMR_W-1:0] WORD_CYCLES = TMR_W'(T_WORD_US * CLK_MHZ),
    parameter logic [TMR_W-1:0] ROW_CYCLES  = TMR_W'(T_ROW_US * CLK_MHZ),
    parameter logic [TMR_W-1:0] PAGE_CYCLES = TMR_W'(T_PAGE_US * CLK_MHZ),
    parameter logic [TMR_W-1:0] BULK_CYCLES = TMR_W'(T_BULK_US * CLK_MHZ),
    parameter logic [FA_W-PAGE_LSB-1:0] LAST_PAGE = 14'h3fff
)(
    // Clock and resets
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              warm_rst,
    // Register port
    input  wire fpec_bus_s         bus,
    output logic [DATA_W-1:0]      rdata,
    // Table store port
    input  wire logic              tbl_wr,
    input  wire logic [FA_W-1:0]   tbl_addr,
    input  wire logic [FA_W-1:0]   tbl_data,
    // Mode pin
    input  wire logic              serial_prog_mode,
    // Core and array side
    output logic                   cpu_stall,
    output fpec_arr_s              arr,
    output logic                   code_protect
);
    // ========================================
    // Control register state
    logic             busy;
    logic             prog_en;
    logic             err;
    logic             erase_sel;
    logic [OP_MSB:0]  op_code;
    logic [2:0]       mode_ff;
    logic             mode_q;
    logic             armed;
    logic             tmr_busy;
    fpec_state_e      state;
    fpec_state_e      next_state;
    logic [IDX_W-1:0] idx;
    logic [FA_W-1:0]  tgt;
    fpec_arr_s        next_arr;
    logic [FA_W-1:0]  latch_mem [0:ROW_WORDS-1];

    // ========================================
    // Address decode
    wire ctl_sel  = (bus.addr == REG_CTRL);
    wire key_sel  = (bus.addr == REG_KEY);
    wire stat_sel = (bus.addr == REG_STAT);
    wire ctl_wr   = bus.wr && ctl_sel;

    // ========================================
    // Start qualification
    wire [OP_MSB:0] new_op    = bus.wdata[OP_MSB:0];
    wire            new_erase = bus.wdata[CTL_ERASE_BIT];
    wire            start_req = ctl_wr && bus.wdata[CTL_WR_BIT] && !busy;
    wire            op_bulk   = new_erase && (new_op == OP_BULK);
    wire            op_word   = !new_erase && (new_op == OP_WORD);
    wire            op_page   = new_erase && (new_op == OP_PAGE);
    wire            op_row    = !new_erase && (new_op == OP_ROW);
    wire            op_ok     = op_row || op_word || op_page || (op_bulk && mode_q);
    // Start beside a warm reset is refused, else busy would hang with the FSM idle
    wire            auth      = armed && bus.wdata[CTL_EN_BIT] && !warm_rst;
    wire            launch    = start_req && auth && op_ok;
    wire            seq_err   = start_req && (!auth || (op_bulk && !mode_q));
    wire            abort     = warm_rst && busy;
    wire            last_page = (tgt[FA_W-1:PAGE_LSB] == LAST_PAGE);
    wire            wipe_cfg  = (op_page && last_page) || op_bulk;

    wire [TMR_W-1:0] tmr_load = op_bulk ? BULK_CYCLES :
                                op_page ? PAGE_CYCLES :
                                op_word ? WORD_CYCLES : ROW_CYCLES;

    wire [DATA_W-1:0] ctl_word  = {busy, prog_en, err, 6'h00, erase_sel, 2'h0, op_code};
    wire [DATA_W-1:0] stat_word = {12'h000, armed, mode_q, code_protect, busy};
    wire [DATA_W-1:0] rd_mux    = ctl_sel  ? ctl_word  :
                                  stat_sel ? stat_word : '0;

    // ========================================
    // Submodules
    fpec_key_detect u_key (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clr     (warm_rst),
        .bus_wr  (bus.wr),
        .key_sel (key_sel),
        .wdata   (bus.wdata[KEY_W-1:0]),
        .armed   (armed)
    );

    fpec_op_timer u_tmr (
        .ref_clk (ref_clk),
        .rst     (rst),
        .start   (launch),
        .abort   (abort),
        .load    (tmr_load),
        .busy    (tmr_busy)
    );

    // ========================================
    // Mode pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_ff <= '0;
            mode_q  <= 1'b0;
        end else begin
            mode_ff <= {mode_ff[1:0], serial_prog_mode};
            if (mode_ff[1] == mode_ff[2])
                mode_q <= mode_ff[2];
        end
    end

    // ========================================
    // Control register, only power-on reset clears it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {busy, prog_en, err, erase_sel, op_code} <= '0;
        end else begin
            if (launch)
                busy <= 1'b1;
            else if (abort || (state == ST_WAIT && !tmr_busy))
                busy <= 1'b0;
            if (ctl_wr && !busy) begin
                prog_en   <= bus.wdata[CTL_EN_BIT];
                erase_sel <= new_erase;
                op_code   <= new_op;
            end
            if (seq_err || abort)
                err <= 1'b1;
            else if (launch)
                err <= 1'b0;
            else if (ctl_wr && !busy)
                err <= bus.wdata[CTL_ERR_BIT];
        end
    end

    // Config words wiped on last-page or bulk erase
    always_ff @(posedge ref_clk) begin
        if (rst)
            code_protect <= 1'b0;
        else if (launch && wipe_cfg)
            code_protect <= 1'b1;
    end

    // ========================================
    // Holding latches and target address
    always_ff @(posedge ref_clk) begin
        if (tbl_wr && !busy) begin
            latch_mem[tbl_addr[IDX_W:1]] <= tbl_data;
            tgt                          <= tbl_addr;
        end
    end

    // ========================================
    // Sequencing FSM
    always_comb begin
        next_state = state;
        next_arr   = '0;
        case (state)
            ST_IDLE: begin
                if (launch)
                    next_state = ST_LOAD;
            end
            ST_LOAD: begin
                if (erase_sel) begin
                    next_arr.erase = 1'b1;
                    next_arr.bulk  = (op_code == OP_BULK);
                    next_arr.addr  = next_arr.bulk ? '0 : {tgt[FA_W-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
                    next_state     = ST_WAIT;
                end else if (op_code == OP_WORD) begin
                    next_arr.wr   = 1'b1;
                    next_arr.addr = tgt;
                    next_arr.data = latch_mem[tgt[IDX_W:1]];
                    next_state    = ST_WAIT;
                end else begin
                    next_arr.wr   = 1'b1;
                    next_arr.addr = {tgt[FA_W-1:ROW_LSB], idx, 1'b0};
                    next_arr.data = latch_mem[idx];
                    if (idx == IDX_LAST)
                        next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!tmr_busy)
                    next_state = ST_DONE;
            end
            ST_DONE: begin
                // Start may land in the very cycle after completion
                if (launch)
                    next_state = ST_LOAD;
                else
                    next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (warm_rst)
            next_state = ST_IDLE;
    end

    always_ff @(posedge ref_clk) begin
        if (rst || warm_rst) begin
            state <= ST_IDLE;
            idx   <= '0;
            arr   <= '0;
        end else begin
            state <= next_state;
            arr   <= next_arr;
            idx   <= (state == ST_LOAD) ? idx + 1'b1 : '0;
        end
    end

    // ========================================
    // Outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata     <= '0;
            cpu_stall <= 1'b0;
        end else begin
            rdata     <= bus.rd ? rd_mux : '0;
            cpu_stall <= launch || (busy && !abort && !(state == ST_WAIT && !tmr_busy));
        end
    end

    // ========================================
    // Assertions
    wire row_go = launch && op_row;

    property p_stall;
        @(posedge ref_clk) disable iff (rst) launch |=> cpu_stall && busy;
    endproperty
    a_stall: assert property (p_stall) else $error("stall missing after launch");

    property p_autoclear;
        @(posedge ref_clk) disable iff (rst) (state == ST_WAIT && !tmr_busy && !abort) |=> !busy && !cpu_stall;
    endproperty
    a_autoclear: assert property (p_autoclear) else $error("start bit not cleared");

    property p_settable;
        @(posedge ref_clk) disable iff (rst) (busy && ctl_wr && !abort && tmr_busy) |=> busy;
    endproperty
    a_settable: assert property (p_settable) else $error("software cleared start bit");

    property p_enable;
        @(posedge ref_clk) disable iff (rst) (start_req && !bus.wdata[CTL_EN_BIT]) |=> !busy && err;
    endproperty
    a_enable: assert property (p_enable) else $error("start without enable");

    property p_unlock;
        @(posedge ref_clk) disable iff (rst) (start_req && !armed) |=> err && !busy;
    endproperty
    a_unlock: assert property (p_unlock) else $error("start without unlock");

    property p_row;
        @(posedge ref_clk) disable iff (rst || warm_rst) row_go |=> ##1 arr.wr[*8];
    endproperty
    a_row: assert property (p_row) else $error("row stream broken");

    property p_bulk_mode;
        @(posedge ref_clk) disable iff (rst) (start_req && op_bulk && !mode_q) |=> !busy ##1 !arr.erase;
    endproperty
    a_bulk_mode: assert property (p_bulk_mode) else $error("bulk erase outside mode");

    property p_unimpl;
        @(posedge ref_clk) disable iff (rst) (start_req && !op_ok) |=> !busy;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("undefined code started");

    property p_reserved;
        @(posedge ref_clk) disable iff (rst) $past(bus.rd && ctl_sel) |-> (rdata[12:7] == '0 && rdata[5:4] == '0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_latch;
        @(posedge ref_clk) disable iff (rst) !busy |=> !arr.wr;
    endproperty
    a_latch: assert property (p_latch) else $error("array written while idle");

    property p_protect;
        @(posedge ref_clk) disable iff (rst) (launch && op_page && last_page) |=> code_protect;
    endproperty
    a_protect: assert property (p_protect) else $error("code protect not set");

    c_row:   cover property (@(posedge ref_clk) disable iff (rst) row_go);
    c_page:  cover property (@(posedge ref_clk) disable iff (rst) launch && op_page);
    c_err:   cover property (@(posedge ref_clk) disable iff (rst) seq_err);
    c_abort: cover property (@(posedge ref_clk) disable iff (rst) abort);
endmodule // fpec_top

// ==== rtl/fpec_pkg.sv ====
// Shared constants and types for the flash program/erase sequencer
package fpec_pkg;
    // ========================================
    // Register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_KEY  = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h2;

    // ========================================
    // Control register fields
    localparam int CTL_WR_BIT    = 15;
    localparam int CTL_EN_BIT    = 14;
    localparam int CTL_ERR_BIT   = 13;
    localparam int CTL_ERASE_BIT = 6;
    localparam int OP_MSB        = 3;
    localparam logic [15:0] CTL_RESET = 16'h0000;

    // ========================================
    // Unlock key
    localparam int KEY_W = 8;
    localparam logic [KEY_W-1:0] KEY_FIRST  = 8'h55;
    localparam logic [KEY_W-1:0] KEY_SECOND = 8'haa;

    // ========================================
    // Flash geometry
    localparam int FA_W      = 24;
    localparam int IDX_W     = 6;
    localparam int ROW_WORDS = 64;
    localparam int ROW_LSB   = 7;
    localparam int PAGE_LSB  = 10;
    localparam logic [IDX_W-1:0] IDX_LAST = 6'h3f;

    // ========================================
    // Operation timing
    localparam int TMR_W     = 24;
    localparam int CLK_MHZ   = 125;
    localparam int T_WORD_US = 40;
    localparam int T_ROW_US  = 2000;
    localparam int T_PAGE_US = 20000;
    localparam int T_BULK_US = 40000;

    typedef enum logic [3:0] {
        OP_ROW  = 4'h1,
        OP_PAGE = 4'h2,
        OP_WORD = 4'h3,
        OP_BULK = 4'hf
    } fpec_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_WAIT = 2'b11,
        ST_DONE = 2'b10
    } fpec_state_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fpec_bus_s;

    typedef struct packed {
        logic            wr;
        logic            erase;
        logic            bulk;
        logic [FA_W-1:0] addr;
        logic [FA_W-1:0] data;
    } fpec_arr_s;
endpackage

// ==== rtl/fpec_key_detect.sv ====
// Unlock key sequence detector
`timescale 1ns/1ns
module fpec_key_detect
    import fpec_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clr,
    // Bus write view
    input  wire logic             bus_wr,
    input  wire logic             key_sel,
    input  wire logic [KEY_W-1:0] wdata,
    // Arming state
    output logic                  armed
);
    logic got_first;
    wire  is_first  = bus_wr && key_sel && (wdata == KEY_FIRST);
    wire  is_second = bus_wr && key_sel && (wdata == KEY_SECOND) && got_first;

    // Any other write breaks or consumes the sequence
    always_ff @(posedge ref_clk) begin
        if (rst || clr) begin
            got_first <= 1'b0;
            armed     <= 1'b0;
        end else if (bus_wr) begin
            got_first <= is_first;
            armed     <= is_second;
        end
    end
endmodule // fpec_key_detect

// ==== rtl/fpec_op_timer.sv ====
// Self-timed operation duration counter
`timescale 1ns/1ns
module fpec_op_timer
    import fpec_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Control
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [TMR_W-1:0] load,
    // Status
    output logic                  busy
);
    logic [TMR_W-1:0] cnt;
    localparam logic [TMR_W-1:0] ONE = 24'h000001;

    always_ff @(posedge ref_clk) begin
        if (rst || abort) begin
            cnt  <= '0;
            busy <= 1'b0;
        end else if (start) begin
            cnt  <= load;
            busy <= 1'b1;
        end else if (busy) begin
            cnt  <= cnt - ONE;
            busy <= (cnt != ONE);
        end
    end
endmodule // fpec_op_timer

// ==== test/fpec_cpu_model.sv ====
// Processor-side model: register bus master and table store source
`timescale 1ns/1ns
module fpec_cpu_model
    import fpec_pkg::*;
(
    // Clock
    input  wire logic              ref_clk,
    // Core view of the block
    input  wire logic              cpu_stall,
    input  wire logic [DATA_W-1:0] rdata,
    // Requests
    output fpec_bus_s              bus,
    output logic                   tbl_wr,
    output logic [FA_W-1:0]        tbl_addr,
    output logic [FA_W-1:0]        tbl_data
);
    initial begin
        bus = '0;
        tbl_wr = 1'b0;
        tbl_addr = '0;
        tbl_data = '0;
    end

    // ========================================
    // Stalled core issues nothing; probe models a debug access
    task automatic hold_off(input bit probe);
        int n;
        n = 0;
        while (!probe && cpu_stall === 1'b1 && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input bit probe = 0);
        hold_off(probe);
        @(posedge ref_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, input bit probe = 0);
        hold_off(probe);
        @(posedge ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: bus.wdata};
        @(posedge ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~bus.wdata};
        @(posedge ref_clk);
        d = rdata;
    endtask

    task automatic unlock();
        wr(REG_KEY, {8'h00, KEY_FIRST});
        wr(REG_KEY, {8'h00, KEY_SECOND});
    endtask

    task automatic tbl(input logic [FA_W-1:0] a, input logic [FA_W-1:0] d);
        @(posedge ref_clk);
        tbl_wr <= 1'b1;
        tbl_addr <= a;
        tbl_data <= d;
        @(posedge ref_clk);
        tbl_wr <= 1'b0;
        tbl_addr <= ~a;
        tbl_data <= ~d;
    endtask
endmodule // fpec_cpu_model

// ==== test/fpec_top_test.sv ====
// Self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ns
module fpec_top_test;
    import fpec_pkg::*;
    localparam logic [TMR_W-1:0] WORD_N = 24'h000064;
    localparam logic [TMR_W-1:0] ROW_N  = 24'h000078;
    localparam logic [TMR_W-1:0] PAGE_N = 24'h00008c;
    localparam logic [TMR_W-1:0] BULK_N = 24'h0000a0;

    logic              ref_clk;
    logic              rst = 1'b1;
    logic              warm_rst = 1'b0;
    logic              serial_prog_mode = 1'b0;
    fpec_bus_s         bus;
    logic [DATA_W-1:0] rdata;
    logic              tbl_wr;
    logic [FA_W-1:0]   tbl_addr;
    logic [FA_W-1:0]   tbl_data;
    logic              cpu_stall;
    logic              code_protect;
    fpec_arr_s         arr;
    int                num_errors = 0;
    int                checked = 0;
    int                stall_n = 0;
    fpec_arr_s         exp_q[$];
    fpec_arr_s         exp_a;
    logic [FA_W-1:0]   latch[ROW_WORDS];
    logic [FA_W-1:0]   a;
    logic [DATA_W-1:0] rv;
    logic [DATA_W-1:0] ctl;

    fpec_top #(.WORD_CYCLES(WORD_N), .ROW_CYCLES(ROW_N), .PAGE_CYCLES(PAGE_N), .BULK_CYCLES(BULK_N)) u_fpec_top (
        .ref_clk(ref_clk), .rst(rst), .warm_rst(warm_rst), .bus(bus), .rdata(rdata), .tbl_wr(tbl_wr),
        .tbl_addr(tbl_addr), .tbl_data(tbl_data), .serial_prog_mode(serial_prog_mode), .cpu_stall(cpu_stall),
        .arr(arr), .code_protect(code_protect));

    fpec_cpu_model u_fpec_cpu_model (.ref_clk(ref_clk), .cpu_stall(cpu_stall), .rdata(rdata), .bus(bus),
        .tbl_wr(tbl_wr), .tbl_addr(tbl_addr), .tbl_data(tbl_data));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ========================================
    // Comparison and closing
    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] exp, input string what);
        u_fpec_cpu_model.rd(ad, rv);
        check(rv, exp, what);
    endtask

    function automatic void expect_arr(input logic w, e, b, input logic [FA_W-1:0] ad, dt);
        exp_q.push_back('{wr: w, erase: e, bulk: b, addr: ad, data: dt});
    endfunction

    task automatic warm_pulse();
        @(posedge ref_clk);
        warm_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        warm_rst <= 1'b0;
    endtask

    // Unlock, start, probe mid-run, then measure the stall
    task automatic launch(input logic [DATA_W-1:0] c, input int cyc, input bit key = 1);
        if (key) u_fpec_cpu_model.unlock();
        stall_n = 0;
        u_fpec_cpu_model.wr(REG_CTRL, c);
        if (cyc > 0) begin
            u_fpec_cpu_model.rd(REG_CTRL, rv, 1);
            check(rv, c, "start bit while active");
            u_fpec_cpu_model.wr(REG_CTRL, 16'h0000, 1);
        end
        repeat (cyc + 40) @(posedge ref_clk);
        if (cyc == 0) begin
            check(stall_n, 0, "stall on refused start");
        end else begin
            check(stall_n >= cyc && stall_n <= cyc + 8, 1'b1, "stall span");
            rd_chk(REG_CTRL, c & 16'h7fff, "start bit after completion");
        end
    endtask

    // ========================================
    // Array side model and stall counter
    always @(posedge ref_clk) begin
        if (cpu_stall === 1'b1) stall_n++;
        if (rst === 1'b0 && (arr.wr === 1'b1 || arr.erase === 1'b1)) begin
            if (exp_q.size() == 0) begin
                check(1'b1, 1'b0, "unexpected array access");
            end else begin
                exp_a = exp_q.pop_front();
                check(arr[2*FA_W+2:FA_W], exp_a[2*FA_W+2:FA_W], "access");
                if (exp_a.wr) check(arr.data, exp_a.data, "array data");
            end
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end

    // ========================================
    // Scenarios
    initial begin
        void'($urandom(32'h0de3));
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(REG_CTRL, 16'h0000, "ctrl reset");
        u_fpec_cpu_model.wr(REG_CTRL, 16'h7fff);
        rd_chk(REG_CTRL, 16'h604f, "unused bits");
        rd_chk(REG_KEY, 16'h0000, "key readback");
        rd_chk(4'h9, 16'h0000, "unmapped read");
        u_fpec_cpu_model.wr(REG_CTRL, 16'h0000);
        launch(16'hc001, 0, 0);
        rd_chk(REG_CTRL, 16'h6001, "start without key");
        launch(16'h8001, 0);
        rd_chk(REG_CTRL, 16'h2001, "start without enable");
        a = FA_W'($urandom()) & 24'h7fff80;
        for (int i = 0; i < ROW_WORDS; i++) begin
            latch[i] = FA_W'($urandom());
            u_fpec_cpu_model.tbl(a + FA_W'(2 * i), latch[i]);
            expect_arr(1'b1, 1'b0, 1'b0, {a[23:7], 6'(i), 1'b0}, latch[i]);
        end
        launch(16'hc001, ROW_N);
        a = FA_W'($urandom()) & 24'h7ffffe;
        latch[0] = FA_W'($urandom());
        u_fpec_cpu_model.tbl(a, latch[0]);
        expect_arr(1'b1, 1'b0, 1'b0, a, latch[0]);
        launch(16'hc003, WORD_N);
        a = FA_W'($urandom()) & 24'h7ffffe;
        u_fpec_cpu_model.tbl(a, 24'h000000);
        expect_arr(1'b0, 1'b1, 1'b0, a & 24'hfffc00, 24'h000000);
        launch(16'hc042, PAGE_N);
        check(code_protect, 1'b0, "protect after ordinary page");
        for (int i = 0; i < 5; i++) begin
            ctl = (i == 0) ? 16'hc002 : (i == 1) ? 16'hc043 : (i == 2) ? 16'hc041 : 16'hc00f;
            if (i == 4) ctl = {9'h180, 1'($urandom()), 2'b00, 4'($urandom_range(4, 14))};
            launch(ctl, 0);
            rd_chk(REG_CTRL, ctl & 16'h7fff, "no-operation code");
        end
        launch(16'hc04f, 0);
        rd_chk(REG_CTRL, 16'h604f, "bulk outside serial mode");
        // Last page erase is deliberate here, notwithstanding
        u_fpec_cpu_model.tbl(24'hfffc40, 24'h000000);
        expect_arr(1'b0, 1'b1, 1'b0, 24'hfffc00, 24'h000000);
        launch(16'hc042, PAGE_N);
        check(code_protect, 1'b1, "protect after last page");
        serial_prog_mode <= 1'b1;
        repeat (5) @(posedge ref_clk);
        expect_arr(1'b0, 1'b1, 1'b1, 24'h000000, 24'h000000);
        launch(16'hc04f, BULK_N);
        rd_chk(REG_STAT, 16'h0006, "status after bulk");
        u_fpec_cpu_model.wr(REG_CTRL, 16'h4042);
        warm_pulse();
        rd_chk(REG_CTRL, 16'h4042, "ctrl kept over warm reset");
        u_fpec_cpu_model.tbl(24'h000100, 24'h123456);
        expect_arr(1'b1, 1'b0, 1'b0, 24'h000100, 24'h123456);
        u_fpec_cpu_model.unlock();
        u_fpec_cpu_model.wr(REG_CTRL, 16'hc003);
        repeat (20) @(posedge ref_clk);
        warm_pulse();
        repeat (5) @(posedge ref_clk);
        check(cpu_stall, 1'b0, "stall after abort");
        rd_chk(REG_CTRL, 16'h6003, "abort flags error");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(REG_CTRL, 16'h0000, "ctrl after power-on reset");
        check(code_protect, 1'b0, "protect after power-on reset");
        check(exp_q.size(), 0, "array accesses missing");
        tally_and_finish();
    end
endmodule // fpec_top_test
